// *** hdl/dma_params.svh ***
// Constants of the DMA channel control block: register indices, field positions,
// reset values. Register byte address is four times the index; data sits in bits 15:0.
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH

// Register indices
`define PREC_IDX        10'h000
`define CMD_IDX         10'h03e
`define CH_REGION       4'h1
`define RL_REGION       5'h04

// Per channel working registers, index 0x40 + ch*8 + field
`define F_SRC           3'h0
`define F_DST           3'h1
`define F_CTR           3'h2
`define F_FRM           3'h3
`define F_MODE          3'h4
`define F_IDX           3'h5

// Per channel reload registers, index 0x80 + ch*4 + field
`define R_GSA           2'h0
`define R_GDA           2'h1
`define R_GCR           2'h2
`define R_GFR           2'h3

// Field positions
`define CMD_SET_BIT     15
`define PREC_PER_CHANNEL_RELOAD_SELECT_BIT 14
`define PREC_PRIO_LSB   8
`define PREC_EN_LSB     0
`define MODE_SSTEP_LSB  0
`define MODE_DSTEP_LSB  2
`define MODE_DWORD_BIT  4
`define MODE_AUTO_BIT   5

// Reset values
`define PREC_RESET      16'h0000
`define MODE_RESET      6'h00
`define WORD_RESET      16'h0000
`define FRM_RESET       8'h00

`endif

// *** hdl/dma_pkg.sv ***
// Types shared by the DMA channel control modules.
// Assumes dma_params.svh supplies the numeric constants.
package dma_pkg;

	// Engine sequence
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RD,
		ST_WR
	} eng_state_e;

	// Post-access address adjustment
	typedef enum logic [1:0] {
		STEP_HOLD = 2'h0,
		STEP_INC  = 2'h1,
		STEP_DEC  = 2'h2,
		STEP_IDX  = 2'h3
	} addr_step_e;

endpackage

// *** hdl/arb_if.sv ***
// Request and grant bundle between the channel control and its arbiter.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface arb_if #(parameter int NCH = 6);
	logic [NCH-1:0] req;
	logic [NCH-1:0] high;
	logic           advance;
	logic [2:0]     gnt;
	logic           gnt_valid;

	modport arb  (input req, input high, input advance, output gnt, output gnt_valid);
	modport user (output req, output high, output advance, input gnt, input gnt_valid);
endinterface

// *** hdl/dma_addr_step.sv ***
// Next-address calculation for one address after an access.
// Assumes a 16-bit address space with wrap-around.
`timescale 1ns/1ps
module dma_addr_step
	import dma_pkg::*;
(
	// Current address and adjustment
	input  wire logic [15:0] addr,
	input  wire logic [1:0]  step,
	input  wire logic [15:0] index,
	// Adjusted address
	output logic      [15:0] next_addr
);

	// Hold, post-increment, post-decrement or add index
	always_comb begin
		case (addr_step_e'(step))
			STEP_HOLD: next_addr = addr;
			STEP_INC:  next_addr = addr + 16'h0001;
			STEP_DEC:  next_addr = addr - 16'h0001;
			STEP_IDX:  next_addr = addr + index;
			default:   next_addr = addr;
		endcase
	end

endmodule

// *** hdl/dma_rr_arbiter.sv ***
// Two-level arbiter: high level before low, round-robin inside each level.
// Assumes requests are stable while advance is low.
`timescale 1ns/1ps
module dma_rr_arbiter #(
	parameter int NCH = 6
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// Requests and grant
	arb_if.arb        a
);

	logic [2:0] last_hi;
	logic [2:0] last_lo;
	logic [2:0] pick_hi;
	logic [2:0] pick_lo;
	logic       any_hi;
	logic       any_lo;

	// Search from the channel after the last one served, per level
	always_comb begin
		int c;
		c       = 0;
		pick_hi = 3'h0;
		pick_lo = 3'h0;
		any_hi  = 1'b0;
		any_lo  = 1'b0;
		for (int k = 1; k <= NCH; k++) begin
			c = (int'(last_hi) + k) % NCH;
			if (!any_hi && a.req[c] && a.high[c]) begin
				any_hi  = 1'b1;
				pick_hi = 3'(c);
			end
			c = (int'(last_lo) + k) % NCH;
			if (!any_lo && a.req[c] && !a.high[c]) begin
				any_lo  = 1'b1;
				pick_lo = 3'(c);
			end
		end
	end

	assign a.gnt_valid = any_hi | any_lo;
	assign a.gnt       = any_hi ? pick_hi : pick_lo;

	// Remember the served channel of the level that won
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			last_hi <= 3'(NCH - 1);
			last_lo <= 3'(NCH - 1);
		end else if (a.advance && any_hi) begin
			last_hi <= pick_hi;
		end else if (a.advance && any_lo) begin
			last_lo <= pick_lo;
		end
	end

endmodule

// *** hdl/dma_channel_ctrl.sv ***
// Channel control of a multi-channel DMA: enable register with set/clear
// command port, priority arbitration, address stepping, counting, reload.
// Assumes a classic Wishbone master and a memory port that acks each access.
//
// Behaviour
// RULE1: command write with bit 15 sets selected enables
// RULE2: command write with bit 15 low clears selected
// RULE3: unselected enable bits keep their state
// RULE4: command register write-only at index 0x3e
// RULE5: software should use command register, not read-modify-write
// RULE6: finished channel clears its own enable bit; code keeps it set when auto_reinit_enable is on
// RULE7: transfer addresses ignore memory map configuration bits
// RULE8: per channel priority, round-robin within a level
// RULE9: source and destination stepped independently per access
// RULE10: auto_reinit_enable reloads addresses and counts after block
// RULE11: reload registers writable anytime without disturbing block
// RULE12: reload select picks channel zero or own set
// RULE13: 8-bit frame counter decrements on last read
// RULE14: frame count zero means one frame
// RULE15: frame counter reloaded after block only with auto_reinit_enable
// RULE16: 16-bit element counter, decrement after each read
// RULE17: element counter reloaded after block in auto_reinit_enable
// RULE18: doubleword moves two halves, one element, both stepped
// RULE19: priority register write overrides completion clear
// RULE20: command write wins over completion on same channel
// RULE21: command register reads zero without side effect
`timescale 1ns/1ps
`include "dma_params.svh"
module dma_channel_ctrl
	import dma_pkg::*;
#(
	parameter int NCH = 6
) (
	// Clock and reset
	input  wire logic           ref_clk,
	input  wire logic           nrst,
	// Wishbone slave
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	input  wire logic           wb_we_i,
	input  wire logic [11:0]    wb_adr_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic [31:0]    wb_dat_i,
	output logic      [31:0]    wb_dat_o,
	output logic                wb_ack_o,
	// Memory port
	output logic                mem_req,
	output logic                mem_we,
	output logic      [15:0]    mem_addr,
	output logic      [15:0]    mem_wdata,
	input  wire logic [15:0]    mem_rdata,
	input  wire logic           mem_ack,
	// Status
	output logic      [NCH-1:0] block_done,
	output logic                busy
);

	// Elaboration check: the command register has six select bits
	if (NCH < 1 || NCH > 6) begin : g_bad_nch
		$error("NCH must lie between 1 and 6");
	end

	// Registers
	logic [15:0] prec;
	logic [15:0] src [NCH];
	logic [15:0] dst [NCH];
	logic [15:0] ctr [NCH];
	logic [15:0] flen [NCH];
	logic [7:0]  frm [NCH];
	logic [5:0]  mode [NCH];
	logic [15:0] idx_r [NCH];
	logic [15:0] gsa [NCH];
	logic [15:0] gda [NCH];
	logic [15:0] gcr [NCH];
	logic [7:0]  gfr [NCH];

	// Engine state
	eng_state_e  st;
	logic [2:0]  ch;
	logic        half;
	logic        blk_end;

	// Bus decode
	logic [9:0]  widx;
	logic        bus_hit;
	logic        wr;
	logic        in_ch;
	logic        in_rl;
	logic [2:0]  ch_c;
	logic [2:0]  fld_c;
	logic [2:0]  ch_r;
	logic [1:0]  fld_r;
	logic        ch_c_ok;
	logic        ch_r_ok;
	logic [15:0] wdat;
	logic [15:0] rd_val;

	// Engine events
	logic        rd_done;
	logic        wr_done;
	logic        dword;
	logic        auto_on;
	logic        elem_rd;
	logic        fin;
	logic [2:0]  rsel;
	logic [15:0] s_next;
	logic [15:0] d_next;
	logic [NCH-1:0] done_mask;

	arb_if #(.NCH(NCH)) arb ();

	assign widx    = wb_adr_i[11:2];
	assign bus_hit = wb_cyc_i & wb_stb_i;
	assign wr      = bus_hit & wb_we_i & wb_ack_o & (wb_sel_i[1:0] == 2'h3);
	assign wdat    = wb_dat_i[15:0];
	assign in_ch   = (widx[9:6] == `CH_REGION);
	assign in_rl   = (widx[9:5] == `RL_REGION);
	assign ch_c    = widx[5:3];
	assign fld_c   = widx[2:0];
	assign ch_r    = widx[4:2];
	assign fld_r   = widx[1:0];
	assign ch_c_ok = in_ch & (int'(ch_c) < NCH);
	assign ch_r_ok = in_rl & (int'(ch_r) < NCH);

	// Current channel attributes
	assign dword   = mode[ch][`MODE_DWORD_BIT];
	assign auto_on = mode[ch][`MODE_AUTO_BIT];
	assign rd_done = (st == ST_RD) & mem_ack;
	assign wr_done = (st == ST_WR) & mem_ack;
	assign elem_rd = rd_done & (~dword | half);
	assign fin     = wr_done & (~dword | half) & blk_end;
	// Shared set unless per-channel reload select is on
	assign rsel    = prec[`PREC_PER_CHANNEL_RELOAD_SELECT_BIT] ? ch : 3'h0; // RULE12

	// Address adjusters, one per direction
	dma_addr_step u_src_step (
		.addr      (src[ch]),
		.step      (mode[ch][`MODE_SSTEP_LSB +: 2]),
		.index     (idx_r[ch]),
		.next_addr (s_next)
	); // RULE9
	dma_addr_step u_dst_step (
		.addr      (dst[ch]),
		.step      (mode[ch][`MODE_DSTEP_LSB +: 2]),
		.index     (idx_r[ch]),
		.next_addr (d_next)
	); // RULE9

	// Arbitration over enabled channels
	assign arb.req     = prec[`PREC_EN_LSB +: NCH];
	assign arb.high    = prec[`PREC_PRIO_LSB +: NCH]; // RULE8
	assign arb.advance = (st == ST_IDLE) & arb.gnt_valid;

	dma_rr_arbiter #(.NCH(NCH)) u_arb (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.a       (arb)
	); // RULE8

	// Wishbone answer one cycle after the request
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_hit & ~wb_ack_o;
			wb_dat_o <= {16'h0000, rd_val};
		end
	end

	// Read multiplexer; command register and unmapped read zero
	always_comb begin
		rd_val = 16'h0000;
		if (widx == `PREC_IDX) begin
			rd_val = prec;
		end else if (widx == `CMD_IDX) begin
			rd_val = 16'h0000; // RULE21
		end else if (ch_c_ok) begin
			case (fld_c)
				`F_SRC:  rd_val = src[ch_c];
				`F_DST:  rd_val = dst[ch_c];
				`F_CTR:  rd_val = ctr[ch_c];
				`F_FRM:  rd_val = {8'h00, frm[ch_c]};
				`F_MODE: rd_val = {10'h000, mode[ch_c]};
				`F_IDX:  rd_val = idx_r[ch_c];
				default: rd_val = 16'h0000;
			endcase
		end else if (ch_r_ok) begin
			case (fld_r)
				`R_GSA:  rd_val = gsa[ch_r];
				`R_GDA:  rd_val = gda[ch_r];
				`R_GCR:  rd_val = gcr[ch_r];
				`R_GFR:  rd_val = {8'h00, gfr[ch_r]};
				default: rd_val = 16'h0000;
			endcase
		end
	end

	// Completion clears the enable unless auto_reinit_enable keeps it running
	always_comb begin
		done_mask = '0;
		if (fin && !auto_on) begin
			done_mask[ch] = 1'b1; // RULE6
		end
	end

	// Priority and enable register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prec <= `PREC_RESET;
		end else begin
			if (wr && widx == `PREC_IDX) begin
				prec <= wdat; // RULE19
			end else if (wr && widx == `CMD_IDX) begin
				for (int i = 0; i < NCH; i++) begin
					if (wdat[i] && wdat[`CMD_SET_BIT]) begin
						prec[`PREC_EN_LSB + i] <= 1'b1; // RULE1 RULE20
					end else if (wdat[i]) begin
						prec[`PREC_EN_LSB + i] <= 1'b0; // RULE2 RULE4
					end else if (done_mask[i]) begin
						prec[`PREC_EN_LSB + i] <= 1'b0; // RULE3 RULE6 RULE20
					end
				end
			end else begin
				prec[`PREC_EN_LSB +: NCH] <= prec[`PREC_EN_LSB +: NCH] & ~done_mask; // RULE6
			end
		end
	end

	// Source and destination addresses
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NCH; i++) begin
				src[i] <= `WORD_RESET;
				dst[i] <= `WORD_RESET;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (wr && ch_c_ok && int'(ch_c) == i && fld_c == `F_SRC) begin
					src[i] <= wdat;
				end else if (fin && auto_on && int'(ch) == i) begin
					src[i] <= gsa[rsel]; // RULE10
				end else if (rd_done && int'(ch) == i) begin
					src[i] <= s_next; // RULE9 RULE18
				end
				if (wr && ch_c_ok && int'(ch_c) == i && fld_c == `F_DST) begin
					dst[i] <= wdat;
				end else if (fin && auto_on && int'(ch) == i) begin
					dst[i] <= gda[rsel]; // RULE10
				end else if (wr_done && int'(ch) == i) begin
					dst[i] <= d_next; // RULE9 RULE18
				end
			end
		end
	end

	// Element and frame counters
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NCH; i++) begin
				ctr[i]  <= `WORD_RESET;
				flen[i] <= `WORD_RESET;
				frm[i]  <= `FRM_RESET;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (wr && ch_c_ok && int'(ch_c) == i && fld_c == `F_CTR) begin
					ctr[i]  <= wdat;
					flen[i] <= wdat;
				end else if (fin && auto_on && int'(ch) == i) begin
					ctr[i]  <= gcr[rsel]; // RULE17 RULE12
					flen[i] <= gcr[rsel];
				end else if (elem_rd && int'(ch) == i) begin
					if (ctr[i] != 16'h0000) begin
						ctr[i] <= ctr[i] - 16'h0001; // RULE16 RULE18
					end else if (frm[i] != 8'h00) begin
						ctr[i] <= flen[i];
					end
				end
				if (wr && ch_c_ok && int'(ch_c) == i && fld_c == `F_FRM) begin
					frm[i] <= wdat[7:0];
				end else if (fin && auto_on && int'(ch) == i) begin
					frm[i] <= gfr[rsel]; // RULE15 RULE12
				end else if (elem_rd && int'(ch) == i && ctr[i] == 16'h0000 && frm[i] != 8'h00) begin
					frm[i] <= frm[i] - 8'h01; // RULE13 RULE14
				end
			end
		end
	end

	// Mode, index and reload registers: software only
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NCH; i++) begin
				mode[i]  <= `MODE_RESET;
				idx_r[i] <= `WORD_RESET;
				gsa[i]   <= `WORD_RESET;
				gda[i]   <= `WORD_RESET;
				gcr[i]   <= `WORD_RESET;
				gfr[i]   <= `FRM_RESET;
			end
		end else if (wr) begin
			for (int i = 0; i < NCH; i++) begin
				if (ch_c_ok && int'(ch_c) == i && fld_c == `F_MODE) begin
					mode[i] <= wdat[5:0];
				end
				if (ch_c_ok && int'(ch_c) == i && fld_c == `F_IDX) begin
					idx_r[i] <= wdat;
				end
				// Reload set only feeds the block at its end
				if (ch_r_ok && int'(ch_r) == i) begin
					case (fld_r)
						`R_GSA:  gsa[i] <= wdat; // RULE11
						`R_GDA:  gda[i] <= wdat; // RULE11
						`R_GCR:  gcr[i] <= wdat; // RULE11
						`R_GFR:  gfr[i] <= wdat[7:0]; // RULE11
						default: gsa[i] <= gsa[i];
					endcase
				end
			end
		end
	end

	// Transfer sequencer: read source, then write destination
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st        <= ST_IDLE;
			ch        <= 3'h0;
			half      <= 1'b0;
			blk_end   <= 1'b0;
			mem_addr  <= 16'h0000;
			mem_wdata <= 16'h0000;
		end else begin
			case (st)
				ST_IDLE: begin
					if (arb.gnt_valid) begin
						ch       <= arb.gnt;
						half     <= 1'b0;
						blk_end  <= 1'b0;
						mem_addr <= src[arb.gnt]; // RULE7
						st       <= ST_RD;
					end
				end
				ST_RD: begin
					if (mem_ack) begin
						mem_wdata <= mem_rdata;
						mem_addr  <= dst[ch]; // RULE7
						if (elem_rd && ctr[ch] == 16'h0000 && frm[ch] == 8'h00) begin
							blk_end <= 1'b1; // RULE14
						end
						st <= ST_WR;
					end
				end
				ST_WR: begin
					if (mem_ack && dword && !half) begin
						half     <= 1'b1; // RULE18
						mem_addr <= src[ch];
						st       <= ST_RD;
					end else if (mem_ack) begin
						half <= 1'b0;
						st   <= ST_IDLE;
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// One-cycle completion pulse per channel
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			block_done <= '0;
		end else begin
			block_done <= '0;
			if (fin) begin
				block_done[ch] <= 1'b1;
			end
		end
	end

	// Memory strobes follow the sequencer state
	assign mem_req = (st == ST_RD) | (st == ST_WR);
	assign mem_we  = (st == ST_WR);
	assign busy    = (st != ST_IDLE);

endmodule

// *** dv/dma_channel_ctrl_assertions.sv ***
// Port checker for the DMA channel control block.
// Assumes it is bound to dma_channel_ctrl and sees only its ports.
`timescale 1ns/1ps
module dma_channel_ctrl_assertions #(
	parameter int NCH = 6
) (
	input wire logic           ref_clk,
	input wire logic           nrst,
	input wire logic           wb_cyc_i,
	input wire logic           wb_stb_i,
	input wire logic           wb_we_i,
	input wire logic [11:0]    wb_adr_i,
	input wire logic [31:0]    wb_dat_o,
	input wire logic           wb_ack_o,
	input wire logic           mem_req,
	input wire logic           mem_we,
	input wire logic [15:0]    mem_addr,
	input wire logic [15:0]    mem_wdata,
	input wire logic [15:0]    mem_rdata,
	input wire logic           mem_ack,
	input wire logic [NCH-1:0] block_done,
	input wire logic           busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic wr_ack_q;
	// Write ack of the previous cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			wr_ack_q <= 1'b0;
		else
			wr_ack_q <= mem_req && mem_we && mem_ack;
	end
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_rd_ack; mem_req && !mem_we && mem_ack; endsequence
	property p_ack_next; s_req |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_cmd_rd_zero; wb_ack_o && !wb_we_i && wb_adr_i[11:2] == 10'h03e |-> wb_dat_o == 32'h0; endproperty
	property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
	property p_rd_wr; s_rd_ack |=> mem_req && mem_we; endproperty
	property p_wdata; s_rd_ack |=> mem_wdata == $past(mem_rdata); endproperty
	property p_done; block_done != '0 |-> wr_ack_q; endproperty
	property p_done_pulse; block_done != '0 |=> block_done == '0; endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_cmd_rd_zero: assert property (p_cmd_rd_zero) else $error("command register read not zero");
	a_hold: assert property (p_hold) else $error("memory request changed before ack");
	a_rd_wr: assert property (p_rd_wr) else $error("no write after read");
	a_wdata: assert property (p_wdata) else $error("write data not read data");
	a_done: assert property (p_done) else $error("done without final write");
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
endmodule

bind dma_channel_ctrl dma_channel_ctrl_assertions #(.NCH(NCH)) i_chk (
	.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
	.block_done(block_done), .busy(busy));

// *** dv/dma_mem_model.sv ***
// Memory on the far side of the DMA memory port.
// Assumes requests hold until ack; answers after lat wait cycles.
`timescale 1ns/1ps
module dma_mem_model (
	// Clock
	input  wire logic        ref_clk,
	// Memory port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack,
	// Wait cycles per access
	input  wire logic [7:0]  lat
);
	logic [15:0] mem [0:255];
	logic [7:0]  cnt;
	// Known fill pattern
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 16'ha500 + 16'(i);
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
		cnt = 8'h00;
	end
	// One ack per access; read data is only good in the ack cycle
	always @(posedge ref_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		cnt <= (mem_req && !mem_ack) ? cnt + 8'h01 : 8'h00;
		if (mem_req && !mem_ack && cnt >= lat) begin
			mem_ack <= 1'b1;
			if (mem_we)
				mem[mem_addr[7:0]] <= mem_wdata;
			else
				mem_rdata <= mem[mem_addr[7:0]];
		end
	end
endmodule

// *** dv/dma_channel_ctrl_tb.sv ***
// Self-checking bench for the DMA channel control block.
// Assumes the memory model on the far side and the bound checker.
`timescale 1ns/1ps
module dma_channel_ctrl_tb;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [7:0]  lat = 8'h00;
	logic [31:0] rdat;
	logic        ack, mreq, mwe, mack, busy;
	logic [15:0] maddr, mwdata, mrdata, q;
	logic [5:0]  done;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc_cnt = 0;
	logic [15:0] rd_log [$];

	always #12.5 ref_clk = ~ref_clk;

	dma_channel_ctrl i_dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_req(mreq),
		.mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwdata), .mem_rdata(mrdata), .mem_ack(mack),
		.block_done(done), .busy(busy));
	dma_mem_model i_mem (.ref_clk(ref_clk), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr),
		.mem_wdata(mwdata), .mem_rdata(mrdata), .mem_ack(mack), .lat(lat));

	// Watchdog and read address log
	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (mreq && !mwe && mack === 1'b1)
			rd_log.push_back(maddr);
		if (cyc_cnt == 30000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic test_done();
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// One classic Wishbone cycle; read data lands in q
	task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'h0};
		sel <= 4'hf;
		wdat <= {16'h0000, d};
		// Ack and read data are taken at the rising edge that sees ack high
		do @(posedge ref_clk); while (ack !== 1'b1);
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [9:0] idx, input logic [15:0] exp);
		bus(1'b0, idx, 16'h0000);
		chk(nm, q, exp);
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
	endtask
	task automatic chan(input int ch, input logic [15:0] s, d, c, f, m);
		logic [15:0] v [5];
		v = '{s, d, c, f, m};
		for (int i = 0; i < 5; i++)
			bus(1'b1, 10'(64 + ch * 8 + i), v[i]);
	endtask
	task automatic reload(input int ch, input logic [15:0] s, d, c, f);
		logic [15:0] v [4];
		v = '{s, d, c, f};
		for (int i = 0; i < 4; i++)
			bus(1'b1, 10'(128 + ch * 4 + i), v[i]);
	endtask
	task automatic wait_done(input int ch);
		do @(negedge ref_clk); while (done[ch] !== 1'b1);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (n < 4) begin
			@(negedge ref_clk);
			n = (busy === 1'b0) ? n + 1 : 0;
		end
	endtask

	// Reset values, plain storage, write-only and unmapped places
	task automatic t_regs();
		rd("prec_rst", 10'h000, 16'h0000);
		bus(1'b1, 10'h000, 16'hffc0);
		bus(1'b1, 10'h03e, 16'h8000);
		rd("prec_noop", 10'h000, 16'hffc0);
		rd("cmd_rd", 10'h03e, 16'h0000);
		rd("prec_after", 10'h000, 16'hffc0);
		bus(1'b1, 10'h3f0, 16'h1234);
		rd("unmapped", 10'h3f0, 16'h0000);
	endtask
	// Set and clear enables two at a time while the engine is stalled
	task automatic t_cmd();
		lat <= 8'hc8;
		bus(1'b1, 10'h03e, 16'h8021);
		rd("set", 10'h000, 16'hffe1);
		bus(1'b1, 10'h03e, 16'h8006);
		rd("set_keep", 10'h000, 16'hffe7);
		bus(1'b1, 10'h03e, 16'h0021);
		rd("clear", 10'h000, 16'hffc6);
		bus(1'b1, 10'h03e, 16'h0006);
		lat <= 8'h00;
		wait_idle();
	endtask
	// Two frames of three elements with slow memory
	task automatic t_copy();
		lat <= 8'h03;
		rd_log.delete();
		chan(2, 16'h0010, 16'h0080, 16'h0002, 16'h0001, 16'h0005);
		bus(1'b1, 10'h03e, 16'h8004);
		wait_done(2);
		wait_idle();
		for (int i = 0; i < 6; i++)
			chk("copy", i_mem.mem[8'h80 + 8'(i)], 16'ha510 + 16'(i));
		chk("reads", 16'(rd_log.size()), 16'h0006);
		rd("auto_clr", 10'h000, 16'h0000);
	endtask
	// Doubleword, source by index offset, destination down
	task automatic t_dword();
		lat <= 8'h00;
		chan(3, 16'h0020, 16'h0090, 16'h0000, 16'h0000, 16'h001b);
		bus(1'b1, 10'h05d, 16'h0004);
		bus(1'b1, 10'h03e, 16'h8008);
		wait_done(3);
		wait_idle();
		chk("dw_lo", i_mem.mem[8'h90], 16'ha520);
		chk("dw_hi", i_mem.mem[8'h8f], 16'ha524);
	endtask
	// Auto_reinit_enable from the shared set, then from the channel's own set
	task automatic t_auto();
		reload(0, 16'h0030, 16'h00a0, 16'h0001, 16'h0000);
		chan(1, 16'h0040, 16'h00b0, 16'h0000, 16'h0000, 16'h0025);
		bus(1'b1, 10'h03e, 16'h8002);
		wait_done(1);
		wait_done(1);
		chk("first", i_mem.mem[8'hb0], 16'ha540);
		chk("rl_a", i_mem.mem[8'ha0], 16'ha530);
		chk("rl_b", i_mem.mem[8'ha1], 16'ha531);
		rd("en_kept", 10'h000, 16'h0002);
		reload(1, 16'h0050, 16'h00c0, 16'h0000, 16'h0000);
		bus(1'b1, 10'h000, 16'h4002);
		// A completion on the write edge still used the shared set
		wait_done(1);
		wait_done(1);
		wait_done(1);
		chk("own_set", i_mem.mem[8'hc0], 16'ha550);
		bus(1'b1, 10'h03e, 16'h0002);
		wait_idle();
	endtask
	// One high channel ahead of two low ones taking turns
	task automatic t_prio();
		chan(0, 16'h0000, 16'h00d0, 16'h0001, 16'h0000, 16'h0005);
		chan(2, 16'h0020, 16'h00d8, 16'h0001, 16'h0000, 16'h0005);
		chan(4, 16'h0060, 16'h00e0, 16'h0001, 16'h0000, 16'h0005);
		rd_log.delete();
		bus(1'b1, 10'h000, 16'h1015);
		wait_idle();
		chk("hi_0", rd_log[0], 16'h0060);
		chk("hi_1", rd_log[1], 16'h0061);
		chk("rr", {13'h0, rd_log[2][5] ^ rd_log[3][5], rd_log[3][5] ^ rd_log[4][5],
			rd_log[4][5] ^ rd_log[5][5]}, 16'h0007);
		rd("prio_kept", 10'h000, 16'h1000);
	endtask

	// Main sequence
	initial begin
		do_reset();
		t_regs();
		t_cmd();
		do_reset();
		t_copy();
		t_dword();
		t_auto();
		do_reset();
		t_prio();
		test_done();
	end
endmodule
